// *** src/ssw_pkg.sv ***
// Summary of operation
// - read command answers with fixed byte only
// - write command answers fixed plus extended byte
// - wake_pending set while wake flags unread
// - reset_pending set after reset until read
// - io low page flag sets io_low_page_source
// - io high page flag sets io_high_page_source
// - regulator high page sets regulator_high_page_source
// - wake flags stay latched until SPI flag read
package ssw_pkg;

	// ********************************************************
	// event sources
	// ********************************************************
	localparam int NSRC = 9;
	localparam int SRC_VREG_LO = 0;
	localparam int SRC_VREG_HI = 1;
	localparam int SRC_IO_LO = 2;
	localparam int SRC_IO_HI = 3;
	localparam int SRC_FIRST_LIN_SOURCE = 4;
	localparam int SRC_SECOND_LIN_SOURCE = 5;
	localparam int SRC_CAN_LOC = 6;
	localparam int SRC_CAN_BUS = 7;
	localparam int SRC_SAFE = 8;

	// ********************************************************
	// frame layout
	// ********************************************************
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] FIX_BITS = 5'h08;
	localparam logic [4:0] CMD_KNOWN_CNT = 5'h01;
	localparam logic [3:0] MSB_IDX = 4'hf;
	localparam int CMD_HI = 15;
	localparam int CMD_LO = 14;
	localparam int ADDR_HI = 13;
	localparam int ADDR_LO = 9;
	localparam int PAGE_BIT = 7;
	localparam logic [1:0] CMD_WRITE = 2'h1;

	// ********************************************************
	// flag register addresses
	// ********************************************************
	localparam logic [4:0] ADDR_REG_FLAGS = 5'h10;
	localparam logic [4:0] ADDR_CAN_FLAGS = 5'h11;
	localparam logic [4:0] ADDR_IO_FLAGS = 5'h12;
	localparam logic [4:0] ADDR_FIRST_LIN_SOURCE_FLAGS = 5'h13;
	localparam logic [4:0] ADDR_SECOND_LIN_SOURCE_FLAGS = 5'h14;
	localparam logic [4:0] ADDR_SAFE_FLAGS = 5'h15;

	// ********************************************************
	// fixed status word bit positions
	// ********************************************************
	localparam int FS_INT = 15;
	localparam int FS_WAKE = 14;
	localparam int FS_RST = 13;
	localparam int FS_CAN_G = 12;
	localparam int FS_LIN_G = 11;
	localparam int FS_IO_G = 10;
	localparam int FS_SAFE_G = 9;
	localparam int FS_REGULATOR_GROUP_SOURCE = 8;
	localparam int FS_CAN_BUS = 7;
	localparam int FS_CAN_LOC = 6;
	localparam int FS_SECOND_LIN_SOURCE = 5;
	localparam int FS_FIRST_LIN_SOURCE = 4;
	localparam int FS_IO_1 = 3;
	localparam int FS_IO_0 = 2;
	localparam int FS_REGULATOR_HIGH_PAGE_SOURCE = 1;
	localparam int FS_REGULATOR_LOW_PAGE_SOURCE = 0;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic POR_FLAG_RST = 1'b1;
	localparam logic MISO_RST = 1'b0;

endpackage : ssw_pkg

// *** src/ssw_flag_if.sv ***
// latched flags between frame logic and flag bank
interface ssw_flag_if
	import ssw_pkg::*;
();
	logic [NSRC-1:0] set_int;
	logic [NSRC-1:0] set_wake;
	logic [NSRC-1:0] set_rst;
	logic [NSRC-1:0] clr;
	logic clr_por;
	logic [NSRC-1:0] int_flags;
	logic [NSRC-1:0] wake_flags;
	logic [NSRC-1:0] rst_flags;
	logic por_flag;

	modport bank (
		input set_int, set_wake, set_rst, clr, clr_por,
		output int_flags, wake_flags, rst_flags, por_flag
	);
	modport ctrl (
		output set_int, set_wake, set_rst, clr, clr_por,
		input int_flags, wake_flags, rst_flags, por_flag
	);
endinterface : ssw_flag_if

// *** src/ssw_flag_bank.sv ***
// sticky per-source flags, set beats clear
module ssw_flag_bank
	import ssw_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// flag carrier
	ssw_flag_if.bank flg
);
	logic [NSRC-1:0] int_r, int_nxt;
	logic [NSRC-1:0] wake_r, wake_nxt;
	logic [NSRC-1:0] rst_r, rst_nxt;
	logic por_r, por_nxt;

	// ********************************************************
	// per-source latches
	// ********************************************************
	// an event in the clearing cycle survives the read
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			int_nxt[i] = flg.set_int[i] | (int_r[i] & ~flg.clr[i]);
			wake_nxt[i] = flg.set_wake[i] | (wake_r[i] & ~flg.clr[i]);
			rst_nxt[i] = flg.set_rst[i] | (rst_r[i] & ~flg.clr[i]);
		end
		por_nxt = por_r & ~flg.clr_por;
	end

	// register only
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			int_r <= '0;
			wake_r <= '0;
			rst_r <= '0;
			por_r <= POR_FLAG_RST;
		end else begin
			int_r <= int_nxt;
			wake_r <= wake_nxt;
			rst_r <= rst_nxt;
			por_r <= por_nxt;
		end
	end

	assign flg.int_flags = int_r;
	assign flg.wake_flags = wake_r;
	assign flg.rst_flags = rst_r;
	assign flg.por_flag = por_r;
endmodule : ssw_flag_bank

// *** src/spi_status_word_response.sv ***
// SPI slave answering write frames with the whole fixed status word, read frames with its upper byte
module spi_status_word_response
	import ssw_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// SPI pins from the host
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	// SPI data back to the host
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	// event pulses from device internals
	input wire logic [NSRC-1:0] int_evt_i,
	input wire logic [NSRC-1:0] wake_evt_i,
	input wire logic [NSRC-1:0] rst_evt_i,
	// observation of the live word
	output logic [15:0] status_word_o
);
	// ********************************************************
	// flag bank
	// ********************************************************
	ssw_flag_if flg ();

	ssw_flag_bank u_bank (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.flg(flg.bank)
	);

	// events come from our own clock domain, no synchroniser
	assign flg.set_int = int_evt_i;
	assign flg.set_wake = wake_evt_i;
	assign flg.set_rst = rst_evt_i;

	// ********************************************************
	// pin synchronisers
	// ********************************************************
	logic [2:0] sclk_r, sclk_nxt;
	logic [2:0] cs_n_r, cs_n_nxt;
	logic [1:0] mosi_r, mosi_nxt;

	// stage 0 feeds stage 1 only; stage 2 is the edge history
	always_comb begin
		sclk_nxt = {sclk_r[1:0], spi_sclk_i};
		cs_n_nxt = {cs_n_r[1:0], spi_cs_n_i};
		mosi_nxt = {mosi_r[0], spi_mosi_i};
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sclk_r <= 3'h0;
			cs_n_r <= 3'h7;
			mosi_r <= 2'h0;
		end else begin
			sclk_r <= sclk_nxt;
			cs_n_r <= cs_n_nxt;
			mosi_r <= mosi_nxt;
		end
	end

	logic sclk_rise, sclk_fall, cs_start, cs_end, cs_act, mosi_s;

	// edges seen on synchronised levels
	assign sclk_rise = sclk_r[1] & ~sclk_r[2];
	assign sclk_fall = ~sclk_r[1] & sclk_r[2];
	assign cs_start = ~cs_n_r[1] & cs_n_r[2];
	assign cs_end = cs_n_r[1] & ~cs_n_r[2];
	assign cs_act = ~cs_n_r[1];
	assign mosi_s = mosi_r[1];

	// ********************************************************
	// fixed status word
	// ********************************************************
	logic [NSRC-1:0] src_any;
	logic [15:0] word;

	// a source bit is lit by any pending class on it
	assign src_any = flg.int_flags | flg.wake_flags | flg.rst_flags;

	always_comb begin
		word = 16'h0000;
		word[FS_INT] = |flg.int_flags;
		word[FS_WAKE] = |flg.wake_flags;
		word[FS_RST] = (|flg.rst_flags) | flg.por_flag;
		word[FS_CAN_G] = src_any[SRC_CAN_LOC] | src_any[SRC_CAN_BUS];
		word[FS_LIN_G] = src_any[SRC_FIRST_LIN_SOURCE] | src_any[SRC_SECOND_LIN_SOURCE];
		word[FS_IO_G] = src_any[SRC_IO_LO] | src_any[SRC_IO_HI];
		word[FS_SAFE_G] = src_any[SRC_SAFE];
		word[FS_REGULATOR_GROUP_SOURCE] = src_any[SRC_VREG_LO] | src_any[SRC_VREG_HI];
		word[FS_CAN_BUS] = src_any[SRC_CAN_BUS];
		word[FS_CAN_LOC] = src_any[SRC_CAN_LOC];
		word[FS_SECOND_LIN_SOURCE] = src_any[SRC_SECOND_LIN_SOURCE];
		word[FS_FIRST_LIN_SOURCE] = src_any[SRC_FIRST_LIN_SOURCE];
		word[FS_IO_1] = src_any[SRC_IO_HI];
		word[FS_IO_0] = src_any[SRC_IO_LO];
		word[FS_REGULATOR_HIGH_PAGE_SOURCE] = src_any[SRC_VREG_HI];
		word[FS_REGULATOR_LOW_PAGE_SOURCE] = src_any[SRC_VREG_LO];
	end

	// ********************************************************
	// frame engine
	// ********************************************************
	logic [15:0] rx_r, rx_nxt;
	logic [15:0] snap_r, snap_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic write_r, write_nxt;
	logic miso_r, miso_nxt;
	logic [15:0] word_r, word_nxt;
	logic [3:0] out_idx;

	assign out_idx = MSB_IDX - cnt_r[3:0];

	// snapshot at select so the word cannot change mid-frame
	always_comb begin
		rx_nxt = rx_r;
		snap_nxt = snap_r;
		cnt_nxt = cnt_r;
		write_nxt = write_r;
		miso_nxt = miso_r;
		word_nxt = word;
		if (cs_start) begin
			snap_nxt = word;
			cnt_nxt = 5'h00;
			write_nxt = 1'b0;
			miso_nxt = word[FS_INT];
		end else if (cs_act) begin
			if (sclk_rise && cnt_r < FRAME_BITS) begin
				rx_nxt = {rx_r[14:0], mosi_s};
				cnt_nxt = cnt_r + 5'h01;
				// second command bit arrives on this edge
				if (cnt_r == CMD_KNOWN_CNT) begin
					write_nxt = ({rx_r[0], mosi_s} == CMD_WRITE);
				end
			end
			if (sclk_fall && cnt_r < FRAME_BITS) begin
				// read frames go quiet after the fixed byte
				if (cnt_r >= FIX_BITS && !write_r) begin
					miso_nxt = 1'b0;
				end else begin
					miso_nxt = snap_r[out_idx];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rx_r <= 16'h0000;
			snap_r <= 16'h0000;
			cnt_r <= 5'h00;
			write_r <= 1'b0;
			miso_r <= MISO_RST;
			word_r <= 16'h0000;
		end else begin
			rx_r <= rx_nxt;
			snap_r <= snap_nxt;
			cnt_r <= cnt_nxt;
			write_r <= write_nxt;
			miso_r <= miso_nxt;
			word_r <= word_nxt;
		end
	end

	assign spi_miso_o = miso_r;
	assign spi_miso_oe_o = cs_act;
	assign status_word_o = word_r;

	// ********************************************************
	// flag read clearing
	// ********************************************************
	logic [NSRC-1:0] clr;
	logic clr_por;
	logic rd_done;
	logic [4:0] addr;
	logic page;

	// only a complete read frame clears; short frames are ignored
	assign rd_done = cs_end && cnt_r == FRAME_BITS && rx_r[CMD_HI:CMD_LO] != CMD_WRITE;
	assign addr = rx_r[ADDR_HI:ADDR_LO];
	assign page = rx_r[PAGE_BIT];

	always_comb begin
		clr = '0;
		clr_por = 1'b0;
		if (rd_done) begin
			unique case (addr)
				ADDR_REG_FLAGS: begin
					clr[SRC_VREG_HI] = page;
					clr[SRC_VREG_LO] = ~page;
					clr_por = ~page;
				end
				ADDR_IO_FLAGS: begin
					clr[SRC_IO_HI] = page;
					clr[SRC_IO_LO] = ~page;
				end
				ADDR_CAN_FLAGS: begin
					clr[SRC_CAN_LOC] = 1'b1;
					clr[SRC_CAN_BUS] = 1'b1;
				end
				ADDR_FIRST_LIN_SOURCE_FLAGS: begin
					clr[SRC_FIRST_LIN_SOURCE] = 1'b1;
				end
				ADDR_SECOND_LIN_SOURCE_FLAGS: begin
					clr[SRC_SECOND_LIN_SOURCE] = 1'b1;
				end
				ADDR_SAFE_FLAGS: begin
					clr[SRC_SAFE] = 1'b1;
				end
				default: begin
					clr = '0; // other addresses touch no flag
				end
			endcase
		end
	end

	assign flg.clr = clr;
	assign flg.clr_por = clr_por;
endmodule : spi_status_word_response

// *** bench/ssw_chk.sv ***
module ssw_chk
	import ssw_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// spi pins
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe_o,
	// events and live word
	input wire logic [NSRC-1:0] int_evt_i,
	input wire logic [NSRC-1:0] wake_evt_i,
	input wire logic [NSRC-1:0] rst_evt_i,
	input wire logic [15:0] status_word_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sw;
	logic [NSRC-1:0] ev;
	logic [3:0] since_cs_r;
	logic [3:0] since_cs_nxt;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	assign sw = status_word_o;
	assign ev = int_evt_i | wake_evt_i | rst_evt_i;
	// cycles since select went high, saturating so idle gaps allow no clear
	always_comb begin
		since_cs_nxt = (since_cs_r == 4'hf) ? 4'hf : since_cs_r + 4'h1;
		if (!spi_cs_n_i) since_cs_nxt = 4'h0;
	end
	always_ff @(posedge sys_clk_i) begin
		since_cs_r <= sys_rst_i ? 4'hf : since_cs_nxt;
	end
	// ***
	// properties
	// ***
	a_wake_set: assert property (|wake_evt_i |-> ##2 sw[FS_WAKE])
		else $error("wake pending missing");
	a_io_low: assert property (ev[SRC_IO_LO] |-> ##2 sw[FS_IO_0] && sw[FS_IO_G])
		else $error("io low source missing");
	a_io_high: assert property (ev[SRC_IO_HI] |-> ##2 sw[FS_IO_1] && sw[FS_IO_G])
		else $error("io high source missing");
	a_vreg_high: assert property (
		ev[SRC_VREG_HI] |-> ##2 sw[FS_REGULATOR_HIGH_PAGE_SOURCE] && sw[FS_REGULATOR_GROUP_SOURCE])
		else $error("regulator high source missing");
	a_group_or: assert property (
		sw[FS_CAN_G] == (sw[FS_CAN_BUS] | sw[FS_CAN_LOC]) && sw[FS_LIN_G] == (sw[FS_SECOND_LIN_SOURCE] | sw[FS_FIRST_LIN_SOURCE]))
		else $error("group bit mismatch");
	a_reset_pend: assert property ($past(sys_rst_i) |-> ##1 sw[FS_RST])
		else $error("reset pending missing");
	a_oe_on: assert property ($fell(spi_cs_n_i) |-> ##[1:4] spi_miso_oe_o)
		else $error("miso not driven");
	a_wake_hold: assert property ($fell(sw[FS_WAKE]) |-> since_cs_r < 4'hc)
		else $error("wake cleared without frame");
endmodule : ssw_chk

bind spi_status_word_response ssw_chk i_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
	.spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .int_evt_i(int_evt_i),
	.wake_evt_i(wake_evt_i), .rst_evt_i(rst_evt_i), .status_word_o(status_word_o));

// *** bench/ssw_host_model.sv ***
module ssw_host_model (
	// clock
	input wire logic sys_clk_i,
	// spi pins toward the device
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	// answer
	input wire logic spi_miso_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy = 1'b0;
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// idle data line toggles so a stale bit never looks valid
	always @(posedge sys_clk_i) begin
		if (!busy) spi_mosi_o <= ~spi_mosi_o;
	end
	// mode 0 frame, msb first, slow phases for the synchronisers
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		busy = 1'b1;
		@(posedge sys_clk_i);
		spi_cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge sys_clk_i);
			spi_mosi_o <= tx[i];
			repeat (5) @(posedge sys_clk_i);
			rx[i] = spi_miso_i;
			spi_sclk_o <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			spi_sclk_o <= 1'b0;
		end
		repeat (4) @(posedge sys_clk_i);
		spi_cs_n_o <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		busy = 1'b0;
	endtask : xfer
endmodule : ssw_host_model

// *** bench/spi_status_word_response_tb_top.sv ***
module spi_status_word_response_tb_top
	import ssw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, sys_rst, sclk, cs_n, mosi, miso, miso_oe;
	logic [2:0][NSRC-1:0] evt;
	logic [15:0] word;
	logic [1:0] cmds [3] = '{2'h0, 2'h1, 2'h3};
	int fl [3][NSRC];
	int por = 1;
	int failures = 0;
	int n_compared = 0;

	spi_status_word_response i_dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
		.spi_miso_oe_o(miso_oe), .int_evt_i(evt[0]), .wake_evt_i(evt[1]),
		.rst_evt_i(evt[2]), .status_word_o(word));
	// a released data line reads inverted, so a late output enable shows up as a bad bit
	ssw_host_model i_host (.sys_clk_i(sys_clk), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
		.spi_mosi_o(mosi), .spi_miso_i(miso_oe ? miso : ~miso));

	// ***
	// reference model and checks
	// ***
	function automatic logic [15:0] exp_word();
		logic [15:0] w;
		logic [NSRC-1:0] p;
		w = 16'h0000;
		for (int s = 0; s < NSRC; s++) begin
			p[s] = (fl[0][s] + fl[1][s] + fl[2][s]) != 0;
			for (int k = 0; k < 3; k++) begin
				if (fl[k][s] != 0) w[15-k] = 1'b1;
			end
		end
		w[13] = w[13] | (por != 0);
		w[12:8] = {p[6] | p[7], p[4] | p[5], p[2] | p[3], p[8], p[0] | p[1]};
		w[7:0] = p[7:0];
		return w;
	endfunction : exp_word
	function automatic void clr(input int s);
		for (int k = 0; k < 3; k++) fl[k][s] = 0;
	endfunction : clr
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_resp(input logic [15:0] got, input logic [15:0] exp);
		chk_word(got, exp);
	endtask : chk_resp
	task automatic summarize();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// one-cycle event, then let flag and word settle
	task automatic pulse(input int k, input int s);
		@(posedge sys_clk);
		evt[k][s] <= 1'b1;
		fl[k][s] = 1;
		@(posedge sys_clk);
		evt <= '0;
		repeat (2) @(negedge sys_clk);
		chk_word(word, exp_word());
	endtask : pulse
	// snapshot answer, then a read of a flag register clears the sources it covers (both CAN sources at 5'h11)
	task automatic frame(input logic [1:0] c, input logic [4:0] a, input logic pg);
		logic [15:0] w, rx;
		w = exp_word();
		i_host.xfer({c, a, 1'b0, pg, 7'($urandom)}, rx);
		chk_resp(rx, (c == CMD_WRITE) ? w : {w[15:8], 8'h00});
		if (c != CMD_WRITE) begin
			case (a)
				5'h10: clr(pg ? 1 : 0);
				5'h11: begin clr(6); clr(7); end
				5'h12: clr(pg ? 3 : 2);
				5'h13: clr(4);
				5'h14: clr(5);
				5'h15: clr(8);
				default: ;
			endcase
			if (a == 5'h10 && !pg) por = 0;
		end
		repeat (4) @(negedge sys_clk);
		chk_word(word, exp_word());
	endtask : frame

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// hang guard, far beyond the planned run
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		summarize();
	end
	initial begin
		sys_rst = 1'b1;
		evt = '0;
		void'($urandom(32'h7598));
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk_word(word, exp_word());
		frame(2'h0, 5'h10, 1'b0);
		for (int n = 0; n < 45; n++) begin
			pulse($urandom_range(2), $urandom_range(NSRC - 1));
			if (n % 3 == 2) frame(cmds[(n / 3) % 3], 5'(16 + $urandom_range(6)), 1'($urandom));
		end
		// reset in mid-run drops every pending flag and raises reset_pending again
		pulse(1, $urandom_range(NSRC - 1));
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int s = 0; s < NSRC; s++) clr(s);
		por = 1;
		repeat (4) @(negedge sys_clk);
		chk_word(word, exp_word());
		frame(2'h1, 5'h10, 1'b0);
		frame(2'h3, 5'h10, 1'b0);
		summarize();
	end
endmodule : spi_status_word_response_tb_top
